// File: rtl/rtcui_pkg.sv
// Purpose: shared constants for the clock update/alarm interrupt block
// Assumes: 8-bit registers on a 4-bit register address, 40 MHz clock
// Notes:   register offsets, bit positions, reset values and timing
package rtcui_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_MINUTE_COUNT = 4'h1;
    localparam logic [3:0] ADDR_HOUR_COUNT = 4'h2;
    localparam logic [3:0] ADDR_WEEKDAY_COUNT = 4'h3;
    localparam logic [3:0] ADDR_DATE_COUNT = 4'h4;
    localparam logic [3:0] ADDR_MINUTE_ALARM = 4'h8;
    localparam logic [3:0] ADDR_HOUR_ALARM = 4'h9;
    localparam logic [3:0] ADDR_WD_ALARM = 4'hA;
    localparam logic [3:0] ADDR_EXT_CONFIG = 4'hD;
    localparam logic [3:0] ADDR_EVENT_FLAGS = 4'hE;
    localparam logic [3:0] ADDR_INT_CONTROL = 4'hF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_ALARM_EXCLUDE = 7;
    localparam int BIT_WD_SELECT = 6;
    localparam int BIT_UPDATE_RATE = 5;
    localparam int BIT_UPDATE_FLAG = 5;
    localparam int BIT_ALARM_FLAG = 3;
    localparam int BIT_UPDATE_IRQ_EN = 5;
    localparam int BIT_ALARM_IRQ_EN = 3;
    localparam int BIT_SOFT_RESET = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hFD;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic [7:0] RST_EXT_CONFIG = 8'h00;
    localparam logic [7:0] RST_INT_CONTROL = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int UPD_PULSE_MAX_NS = 7800000;
    // longest time, so rounded down
    localparam int UPD_PULSE_CYC = UPD_PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int UPD_CNT_W = 19;
endpackage : rtcui_pkg

// File: rtl/rtcui_irq.sv
// Purpose: update and alarm interrupt logic of a real-time clock
// Assumes: time base pulses and current time come from same-clock logic
// Notes:   interrupt pin is open drain, two signals, oe low drives it
//
// What this block does
// - update-rate bit 0 gives per-second events, 1 per-minute events
// - each update event sets the update flag, held until written 0
// - writing 1 to update or alarm flag does nothing; 0 clears
// - clearing the update flag leaves an asserted update low in place
// - enabled update event pulls pin low, released within 7.8 ms
// - update enable 0 keeps update low off the pin; clearing enable ends it
// - pin is shared; other sources hold it low with update enable 0
// - alarm fires when minute, hour, weekday-or-date settings match
// - alarm matches only when the time counters advance into it
// - alarm flag stays set until software clears it
// - enabled alarm holds pin low until flag or enable is cleared
// - alarm enable 1 to 0 releases the pin at once
// - alarm flag 1 to 0 releases the pin at once
// - alarm with enable 0 leaves pin released, flag still set
// - soft reset bit 1 suppresses alarm events
// - select 0 compares weekday bits, 1 compares date
// - fixed-zero bits ignore writes and read 0
// - alarm register with exclude bit set is left out of compare
// - all three excluded gives one alarm per minute
// - weekday alarm holds a bit per day, any day set matches
`timescale 1ns/1ps
`default_nettype none
module rtcui_irq
    import rtcui_pkg::*;
#(
    parameter int P_UPD_PULSE_CYC = UPD_PULSE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sec_update,
    input wire logic i_min_update,
    input wire logic [6:0] i_cur_minute,
    input wire logic [5:0] i_cur_hour,
    input wire logic [6:0] i_cur_weekday,
    input wire logic [5:0] i_cur_date,
    input wire logic [3:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_int_n_out,
    output logic o_int_n_oe_n
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] minute_alarm_reg;
    logic [7:0] hour_alarm_reg;
    logic [7:0] wd_alarm_reg;
    logic [7:0] ext_config_reg;
    logic [7:0] int_control_reg;
    logic update_event_flag_reg;
    logic update_event_flag_next;
    logic alarm_event_flag_reg;
    logic alarm_event_flag_next;
    logic upd_low_reg;
    logic upd_low_next;
    logic [UPD_CNT_W-1:0] upd_cnt_reg;
    logic [UPD_CNT_W-1:0] upd_cnt_next;
    logic [7:0] rdata_next;
    logic drive_next;
    logic [4:0] wr_sel;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic update_rate_select = ext_config_reg[BIT_UPDATE_RATE];
    wire logic weekday_or_date_select = ext_config_reg[BIT_WD_SELECT];
    wire logic update_irq_enable = int_control_reg[BIT_UPDATE_IRQ_EN];
    wire logic alarm_irq_enable = int_control_reg[BIT_ALARM_IRQ_EN];
    wire logic soft_reset = int_control_reg[BIT_SOFT_RESET];
    wire logic wr_flags = i_reg_wr && (i_reg_addr == ADDR_EVENT_FLAGS);
    wire logic wr_alarm_any = wr_sel[0] | wr_sel[1] | wr_sel[2];

    // per-register write strobes, one per writable storage register
    localparam logic [3:0] WR_ADDRS [0:4] = '{ADDR_MINUTE_ALARM,
        ADDR_HOUR_ALARM, ADDR_WD_ALARM, ADDR_EXT_CONFIG, ADDR_INT_CONTROL};
    genvar gi;
    generate
        // time counters live outside, so no strobe is made for them
        for (gi = 0; gi < 5; gi++) begin : g_wr
            assign wr_sel[gi] = i_reg_wr && (i_reg_addr == WR_ADDRS[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // time update event
    // ------------------------------------------------------------------
    // soft reset stops update events as well as alarms
    wire logic upd_tick = update_rate_select ? i_min_update : i_sec_update;
    wire logic upd_evt = upd_tick && !soft_reset;

    // ------------------------------------------------------------------
    // alarm compare
    // ------------------------------------------------------------------
    // compare only on the minute advance, so writing the present time
    // cannot fire at once; the time inputs already show the new value
    wire logic min_hit = minute_alarm_reg[BIT_ALARM_EXCLUDE] ||
        (minute_alarm_reg[6:0] == i_cur_minute);
    // bit 6 of the hour alarm is plain storage, kept out of the compare
    wire logic hour_hit = hour_alarm_reg[BIT_ALARM_EXCLUDE] ||
        (hour_alarm_reg[5:0] == i_cur_hour);
    wire logic day_hit_week = |(wd_alarm_reg[6:0] & i_cur_weekday);
    wire logic day_hit_date = (wd_alarm_reg[5:0] == i_cur_date);
    wire logic day_hit = wd_alarm_reg[BIT_ALARM_EXCLUDE] ||
        (weekday_or_date_select ? day_hit_date : day_hit_week);
    // all three excluded leaves a match on every minute advance
    wire logic alarm_match = min_hit && hour_hit && day_hit;
    wire logic alm_evt = i_min_update && alarm_match && !soft_reset;

    // ------------------------------------------------------------------
    // flag next values; a set in the clear cycle wins
    // ------------------------------------------------------------------
    wire logic uf_clr = wr_flags && !i_reg_wdata[BIT_UPDATE_FLAG];
    wire logic af_clr = wr_flags && !i_reg_wdata[BIT_ALARM_FLAG];
    assign update_event_flag_next = upd_evt ||
        (update_event_flag_reg && !uf_clr);
    assign alarm_event_flag_next = alm_evt ||
        (alarm_event_flag_reg && !af_clr);

    // ------------------------------------------------------------------
    // update low pulse timer
    // ------------------------------------------------------------------
    // the update flag is not looked at, so clearing it cannot end the
    // pulse; only the timer or the enable ends it
    wire logic upd_start = upd_evt && update_irq_enable;
    wire logic upd_done = (upd_cnt_reg == UPD_CNT_W'(1));
    assign upd_cnt_next = upd_start ? UPD_CNT_W'(P_UPD_PULSE_CYC) :
        (upd_low_reg ? upd_cnt_reg - UPD_CNT_W'(1) : upd_cnt_reg);
    assign upd_low_next = update_irq_enable &&
        (upd_start || (upd_low_reg && !upd_done));

    // ------------------------------------------------------------------
    // shared open-drain pin
    // ------------------------------------------------------------------
    // alarm level follows flag and enable directly, no auto release
    wire logic alm_low = alarm_event_flag_reg && alarm_irq_enable;
    assign drive_next = upd_low_reg || alm_low;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // time registers show the counters; fixed-zero bits padded to 0
    wire logic [7:0] flags_view = {2'b00, update_event_flag_reg, 1'b0,
        alarm_event_flag_reg, 3'b000};
    always_comb begin
        case (i_reg_addr)
            ADDR_MINUTE_COUNT: rdata_next = {1'b0, i_cur_minute};
            ADDR_HOUR_COUNT: rdata_next = {2'b00, i_cur_hour};
            ADDR_WEEKDAY_COUNT: rdata_next = {1'b0, i_cur_weekday};
            ADDR_DATE_COUNT: rdata_next = {2'b00, i_cur_date};
            ADDR_MINUTE_ALARM: rdata_next = minute_alarm_reg;
            ADDR_HOUR_ALARM: rdata_next = hour_alarm_reg;
            ADDR_WD_ALARM: rdata_next = wd_alarm_reg;
            ADDR_EXT_CONFIG: rdata_next = ext_config_reg;
            ADDR_EVENT_FLAGS: rdata_next = flags_view;
            ADDR_INT_CONTROL: rdata_next = int_control_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // alarm registers also serve as plain storage when unused
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            minute_alarm_reg <= RST_ALARM;
            hour_alarm_reg <= RST_ALARM;
            wd_alarm_reg <= RST_ALARM;
            ext_config_reg <= RST_EXT_CONFIG;
            int_control_reg <= RST_INT_CONTROL;
        end else begin
            if (wr_sel[0]) minute_alarm_reg <= i_reg_wdata;
            if (wr_sel[1]) hour_alarm_reg <= i_reg_wdata;
            if (wr_sel[2]) wd_alarm_reg <= i_reg_wdata;
            if (wr_sel[3]) ext_config_reg <= i_reg_wdata;
            if (wr_sel[4]) int_control_reg <= i_reg_wdata & CTRL_WRITE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // flags, timer, pin and read data
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            update_event_flag_reg <= 1'b0;
            alarm_event_flag_reg <= 1'b0;
            upd_low_reg <= 1'b0;
            upd_cnt_reg <= '0;
            o_reg_rdata <= 8'h00;
            o_int_n_out <= 1'b0;
            o_int_n_oe_n <= 1'b1;
        end else begin
            update_event_flag_reg <= update_event_flag_next;
            alarm_event_flag_reg <= alarm_event_flag_next;
            upd_low_reg <= upd_low_next;
            upd_cnt_reg <= upd_cnt_next;
            if (i_reg_rd) o_reg_rdata <= rdata_next;
            o_int_n_out <= 1'b0;
            o_int_n_oe_n <= !drive_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // age of the current update low pulse, for the release bound
    logic [UPD_CNT_W-1:0] upd_age_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            upd_age_reg <= '0;
        end else begin
            upd_age_reg <= upd_low_next ?
                (upd_start ? '0 : upd_age_reg + UPD_CNT_W'(1)) : '0;
        end
    end

    sequence seq_upd_fire;
        upd_evt && update_irq_enable;
    endsequence
    // the timer flop answers first, the pin flop one cycle later
    sequence seq_pin_low;
        ##1 upd_low_reg ##1 !o_int_n_oe_n;
    endsequence
    sequence seq_alarm_fire;
        alm_evt && alarm_irq_enable;
    endsequence

    chk_update_rate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        upd_evt == (!soft_reset &&
            (ext_config_reg[BIT_UPDATE_RATE] ? i_min_update : i_sec_update)))
        else $error("update event does not follow rate select");
    chk_uf_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        upd_evt |=> update_event_flag_reg)
        else $error("update flag not set by update event");
    chk_flag_write_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_flags && i_reg_wdata[BIT_UPDATE_FLAG] && i_reg_wdata[BIT_ALARM_FLAG]
        |=> update_event_flag_reg ==
            ($past(update_event_flag_reg) || $past(upd_evt)) &&
            alarm_event_flag_reg ==
            ($past(alarm_event_flag_reg) || $past(alm_evt)))
        else $error("writing one changed a flag");
    chk_uf_clear_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        upd_low_reg && uf_clr && update_irq_enable && !wr_sel[4] && !upd_done
        |=> upd_low_reg)
        else $error("update flag clear released the pin");
    chk_upd_pulse_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (seq_upd_fire and !wr_sel[4]) |-> seq_pin_low)
        else $error("enabled update event did not pull pin low");
    chk_upd_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        upd_low_reg |-> upd_age_reg < UPD_CNT_W'(P_UPD_PULSE_CYC))
        else $error("update low pulse longer than its limit");
    chk_uie_off_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !update_irq_enable |=> !upd_low_reg)
        else $error("update low kept while enable is off");
    chk_shared_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        alm_low && !update_irq_enable |=> !o_int_n_oe_n)
        else $error("alarm low lost while update enable off");
    chk_alarm_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        min_hit && hour_hit && day_hit && i_min_update && !soft_reset
        |=> alarm_event_flag_reg)
        else $error("alarm match did not set the alarm flag");
    chk_alarm_no_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_alarm_any && !i_min_update && !alarm_event_flag_reg
        |=> !alarm_event_flag_reg)
        else $error("alarm fired without a minute advance");
    chk_alarm_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        alarm_event_flag_reg && !af_clr |=> alarm_event_flag_reg)
        else $error("alarm flag dropped without a clear");
    chk_alarm_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (seq_alarm_fire and !wr_sel[4]) |-> ##2 !o_int_n_oe_n)
        else $error("enabled alarm did not pull pin low");
    chk_aie_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !alarm_irq_enable && !upd_low_reg |=> o_int_n_oe_n)
        else $error("pin held with alarm enable off");
    chk_af_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !alarm_event_flag_reg && !upd_low_reg |=> o_int_n_oe_n)
        else $error("pin held with alarm flag clear");
    chk_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        soft_reset && !update_event_flag_reg && !alarm_event_flag_reg
        |=> !update_event_flag_reg && !alarm_event_flag_reg)
        else $error("event raised under soft reset");
    chk_zero_bits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_reg_rd && i_reg_addr == ADDR_EVENT_FLAGS |=> o_reg_rdata[7:6] == 2'b00)
        else $error("fixed-zero flag bits read nonzero");
endmodule : rtcui_irq
`default_nettype wire

// File: verif/rtcui_timebase.sv
// Purpose: stand-in for the time base that feeds the interrupt block
// Assumes: same clock as the interrupt block, driven just after the edge
// Notes:   pulses last one cycle; the time is a level held between ticks
`timescale 1ns/1ps
`default_nettype none
module rtcui_timebase (
    input wire logic i_ref_clk,
    output logic o_sec,
    output logic o_min,
    output logic [6:0] o_minute,
    output logic [5:0] o_hour,
    output logic [6:0] o_weekday,
    output logic [5:0] o_date
);
    // idle: no pulses, time at zero until the first minute tick
    initial begin
        o_sec = 1'b0;
        o_min = 1'b0;
        o_minute = 7'h00;
        o_hour = 6'h00;
        o_weekday = 7'h00;
        o_date = 6'h00;
    end

    // a minute tick also rolls the seconds, so both pulse together;
    // the new time already shows in the pulse cycle
    task automatic tick(input bit m, input logic [6:0] mi,
                        input logic [5:0] h, input logic [6:0] wd,
                        input logic [5:0] d);
        @(posedge i_ref_clk);
        #1;
        if (m) begin
            o_minute = mi;
            o_hour = h;
            o_weekday = wd;
            o_date = d;
        end
        o_sec = 1'b1;
        o_min = m;
        @(posedge i_ref_clk);
        #1;
        o_sec = 1'b0;
        o_min = 1'b0;
    endtask : tick
endmodule : rtcui_timebase
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the update and alarm interrupt block
// Assumes: short update pulse parameter, time base stand-in on far side
// Notes:   read answers and pin samples share one queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rtcui_pkg::*;
;
    localparam int P_PULSE = 40;
    localparam logic [3:0] FL = ADDR_EVENT_FLAGS;
    localparam logic [3:0] CT = ADDR_INT_CONTROL;
    localparam logic [3:0] EX = ADDR_EXT_CONFIG;
    localparam logic [3:0] RA[7] = '{ADDR_MINUTE_ALARM, ADDR_HOUR_ALARM,
        ADDR_WD_ALARM, EX, FL, CT, 4'h5};
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pin_chk = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic sec, mn, int_out, int_oe_n;
    logic [6:0] cmin, cwd;
    logic [5:0] chour, cdate;
    logic [7:0] rdata;
    logic [8:0] exp_q[$];
    int num_errors = 0;
    int total_checks = 0;
    integer seed = 32'h815D68F4;
    logic [31:0] rnd;
    // open-drain pin with a pull-up: released means high
    wire int_n = int_oe_n ? 1'b1 : int_out;

    always #12.5 i_ref_clk = ~i_ref_clk;

    rtcui_irq #(.P_UPD_PULSE_CYC(P_PULSE)) dut_u (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sec_update(sec),
        .i_min_update(mn), .i_cur_minute(cmin), .i_cur_hour(chour),
        .i_cur_weekday(cwd), .i_cur_date(cdate), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_int_n_out(int_out),
        .o_int_n_oe_n(int_oe_n));

    rtcui_timebase tbase_u (
        .i_ref_clk(i_ref_clk), .o_sec(sec), .o_min(mn), .o_minute(cmin),
        .o_hour(chour), .o_weekday(cwd), .o_date(cdate));

    // oldest note is compared once the answer has settled after the edge
    always @(posedge i_ref_clk) begin : mon
        logic t, p;
        logic [8:0] e, got;
        t = rd;
        p = pin_chk;
        #2;
        if (t || p) begin
            e = exp_q.pop_front();
            got = p ? {1'b1, 7'h00, int_n} : {1'b0, rdata};
            total_checks++;
            if (got !== e) begin
                num_errors++;
                $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
            end
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge i_ref_clk);
        #1;
        wr = 1'b0;
    endtask : wr_reg

    // p=0 reads address a, p=1 samples the pin; e is the expectation
    task automatic look(input bit p, input logic [3:0] a,
                        input logic [7:0] e);
        exp_q.push_back({p, e});
        @(posedge i_ref_clk);
        #1;
        addr = a;
        rd = !p;
        pin_chk = p;
        @(posedge i_ref_clk);
        #1;
        rd = 1'b0;
        pin_chk = 1'b0;
    endtask : look

    // bounded wait for the pin to let go
    task automatic wait_release(input int lim);
        int n;
        n = 0;
        while (int_n !== 1'b1 && n < lim) begin
            @(posedge i_ref_clk);
            n++;
        end
        if (int_n !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b1, int_n);
            tally_and_finish();
        end
    endtask : wait_release

    // minute tick, flags read back, then flags cleared
    task automatic alarm_try(input logic [6:0] mi, input logic [5:0] h,
                             input logic [6:0] wd, input logic [5:0] d,
                             input logic [7:0] e);
        tbase_u.tick(1'b1, mi, h, wd, d);
        look(0, FL, e);
        wr_reg(FL, 8'h00);
    endtask : alarm_try

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin : main
        repeat (6) @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        // reset values, unmapped address, fixed-zero bits
        foreach (RA[i]) look(0, RA[i], 8'h00);
        wr_reg(CT, 8'hFF);
        look(0, CT, 8'hFD);
        wr_reg(CT, 8'h00);
        wr_reg(FL, 8'hFF);
        look(0, FL, 8'h00);
        rnd = $random(seed);
        wr_reg(ADDR_HOUR_ALARM, rnd[7:0]);
        look(0, ADDR_HOUR_ALARM, rnd[7:0]);
        $display("registers test done");
        // per-second update, sticky flag, pulse outlives flag clear
        wr_reg(CT, 8'h20);
        tbase_u.tick(1'b0, 7'h00, 6'h00, 7'h00, 6'h00);
        look(1, 4'h0, 8'h00);
        look(0, FL, 8'h20);
        wr_reg(FL, 8'hFF);
        look(0, FL, 8'h20);
        wr_reg(FL, 8'hDF);
        look(1, 4'h0, 8'h00);
        look(0, FL, 8'h00);
        wait_release(P_PULSE + 4);
        look(1, 4'h0, 8'h01);
        // per-minute rate, enable cleared while low releases the pin
        wr_reg(EX, 8'h20);
        tbase_u.tick(1'b0, 7'h00, 6'h00, 7'h00, 6'h00);
        look(0, FL, 8'h00);
        tbase_u.tick(1'b1, 7'h12, 6'h03, 7'h01, 6'h04);
        look(0, FL, 8'h20);
        look(1, 4'h0, 8'h00);
        look(0, ADDR_MINUTE_COUNT, 8'h12);
        look(0, ADDR_HOUR_COUNT, 8'h03);
        look(0, ADDR_WEEKDAY_COUNT, 8'h01);
        look(0, ADDR_DATE_COUNT, 8'h04);
        wr_reg(CT, 8'h00);
        look(1, 4'h0, 8'h01);
        wr_reg(FL, 8'h00);
        tbase_u.tick(1'b1, 7'h13, 6'h03, 7'h01, 6'h04);
        look(1, 4'h0, 8'h01);
        wr_reg(FL, 8'h00);
        $display("update test done");
        // alarm set up with the enable low, then fired disabled
        wr_reg(CT, 8'h00);
        wr_reg(EX, 8'h00);
        wr_reg(ADDR_MINUTE_ALARM, 8'h30);
        wr_reg(ADDR_HOUR_ALARM, 8'h07);
        wr_reg(ADDR_WD_ALARM, 8'h22);
        rnd = $random(seed);
        tbase_u.tick(1'b1, 7'h30, 6'h07, 7'h02, rnd[5:0]);
        look(1, 4'h0, 8'h01);
        look(0, FL, 8'h28);
        wr_reg(FL, 8'h00);
        tbase_u.tick(1'b0, 7'h00, 6'h00, 7'h00, 6'h00);
        look(0, FL, 8'h20);
        wr_reg(FL, 8'h00);
        // enabled alarm holds the pin until the flag goes
        wr_reg(CT, 8'h08);
        rnd = $random(seed);
        tbase_u.tick(1'b1, 7'h30, 6'h07, 7'h20, rnd[5:0]);
        look(1, 4'h0, 8'h00);
        wr_reg(FL, 8'h08);
        look(0, FL, 8'h08);
        look(1, 4'h0, 8'h00);
        wr_reg(FL, 8'h00);
        look(1, 4'h0, 8'h01);
        alarm_try(7'h30, 6'h07, 7'h04, rnd[11:6], 8'h20);
        // alarm shares the pin; clearing the enable releases it
        tbase_u.tick(1'b1, 7'h30, 6'h07, 7'h02, rnd[5:0]);
        tbase_u.tick(1'b0, 7'h00, 6'h00, 7'h00, 6'h00);
        look(1, 4'h0, 8'h00);
        wr_reg(CT, 8'h00);
        look(1, 4'h0, 8'h01);
        look(0, FL, 8'h28);
        wr_reg(FL, 8'h00);
        $display("alarm pin test done");
        // date target, excluded registers, soft reset
        wr_reg(EX, 8'h40);
        wr_reg(ADDR_WD_ALARM, 8'h15);
        alarm_try(7'h30, 6'h07, 7'h02, 6'h16, 8'h20);
        alarm_try(7'h30, 6'h07, rnd[18:12], 6'h15, 8'h28);
        wr_reg(ADDR_HOUR_ALARM, 8'h80);
        alarm_try(7'h30, 6'h11, 7'h01, 6'h15, 8'h28);
        wr_reg(ADDR_MINUTE_ALARM, 8'h80);
        wr_reg(ADDR_WD_ALARM, 8'h80);
        alarm_try(7'h45, 6'h22, rnd[25:19], rnd[31:26], 8'h28);
        wr_reg(CT, 8'h01);
        alarm_try(7'h46, 6'h22, 7'h01, 6'h15, 8'h00);
        $display("alarm match test done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
